// ---- sts1pj_defs.svh ----
// How it works
// - empty buffer inserts one dummy byte
// - dummy byte sits right after H3
// - stuff frame inverts increment indicator bits
// - next frame restores bits, pointer plus one
// - full buffer moves payload byte, never drops
// - moved payload byte rides in H3 slot
// - negative frame inverts decrement indicator bits
// - next frame restores bits, pointer minus one
// - pointer is low ten bits, above 0x30F invalid
// - pointer zero puts J1 after H3
`ifndef STS1PJ_DEFS_SVH
`define STS1PJ_DEFS_SVH

// ----------------------------------------
// frame geometry
// ----------------------------------------
`define STS1PJ_ROWS      4'h9
`define STS1PJ_COLS      7'h5A
`define STS1PJ_TOH_COLS  7'h03
`define STS1PJ_PTR_ROW   4'h3
`define STS1PJ_H1_COL    7'h00
`define STS1PJ_H2_COL    7'h01
`define STS1PJ_H3_COL    7'h02

// ----------------------------------------
// pointer word
// ----------------------------------------
`define STS1PJ_NDF_NORM  4'h6
`define STS1PJ_SS_BITS   2'h0
`define STS1PJ_PTR_MAX   10'h30F
`define STS1PJ_PTR_RST   10'h000
`define STS1PJ_I_MASK    10'h2AA
`define STS1PJ_D_MASK    10'h155
`define STS1PJ_STUFF     8'h00
`define STS1PJ_IDLE_TOH  8'h00

`endif

// ---- sts1pj_pkg.sv ----
package sts1pj_pkg;

  typedef enum logic [1:0] {
    ADJ_NONE,
    ADJ_INC,
    ADJ_DEC
  } sts1pj_adj_t;

  typedef struct packed {
    logic       valid;
    logic       frameStart;
    logic [7:0] data;
  } sts1pj_byte_t;

endpackage

// ---- sts1pj_slip_buffer.sv ----
`timescale 1ns/1ps
`default_nettype none

module sts1pj_slip_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             wrValid,
  input  wire logic [WIDTH-1:0] wrData,
  output logic                  wrReady,
  // drain side
  input  wire logic             rdTake,
  output logic                  rdValid,
  output logic [WIDTH-1:0]      rdData,
  output logic [AW:0]           fill
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    wrPtr_nxt;
  logic [AW-1:0]    rdPtr_r;
  logic [AW-1:0]    rdPtr_nxt;
  logic [AW:0]      fill_r;
  logic [AW:0]      fill_nxt;
  logic             doWr;
  logic             doRd;

  assign wrReady = (fill_r != DEPTH[AW:0]);
  assign rdValid = (fill_r != '0);
  assign rdData  = mem[rdPtr_r];
  assign fill    = fill_r;

  // ----------------------------------------
  // pointers
  // ----------------------------------------
  always_comb begin
    doWr      = wrValid && wrReady;
    doRd      = rdTake && rdValid;
    wrPtr_nxt = wrPtr_r;
    rdPtr_nxt = rdPtr_r;
    fill_nxt  = fill_r;
    if (doWr) begin
      wrPtr_nxt = (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
    end
    if (doRd) begin
      rdPtr_nxt = (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
    end
    if (doWr && !doRd) begin
      fill_nxt = fill_r + 1'b1;
    end else if (doRd && !doWr) begin
      fill_nxt = fill_r - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      fill_r  <= '0;
    end else begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      fill_r  <= fill_nxt;
    end
  end

  // storage has no reset; contents are don't-care until written
  always_ff @(posedge sys_clk) begin
    if (doWr) begin
      mem[wrPtr_r] <= wrData;
    end
  end

endmodule

`default_nettype wire

// ---- sts1pj_justifier.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sts1pj_defs.svh"

module sts1pj_justifier #(
  parameter int          DEPTH     = 16,
  parameter int          LOW_MARK  = 2,
  parameter int          HIGH_MARK = 14,
  parameter logic [9:0]  INIT_PTR  = `STS1PJ_PTR_RST
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  // incoming payload bytes (write side)
  input  wire logic                 inValid,
  input  wire logic [7:0]           inByte,
  output logic                      inReady,
  // outgoing byte slots (read side)
  input  wire logic                 slotTick,
  output sts1pj_pkg::sts1pj_byte_t  streamOut,
  // status
  output logic [9:0]                ptrValue,
  output logic                      ptrValid,
  output logic                      incEvent,
  output logic                      decEvent
);

  localparam int AW = $clog2(DEPTH);

  logic [3:0]                  row_r;
  logic [3:0]                  row_nxt;
  logic [6:0]                  col_r;
  logic [6:0]                  col_nxt;
  logic [9:0]                  ptr_r;
  logic [9:0]                  ptr_nxt;
  sts1pj_pkg::sts1pj_adj_t     mode_r;
  sts1pj_pkg::sts1pj_adj_t     mode_nxt;
  sts1pj_pkg::sts1pj_byte_t    out_r;
  sts1pj_pkg::sts1pj_byte_t    out_nxt;
  logic                        incEv_r;
  logic                        incEv_nxt;
  logic                        decEv_r;
  logic                        decEv_nxt;
  logic                        popReq;
  logic                        bufValid;
  logic [7:0]                  bufByte;
  logic [AW:0]                 fill;
  logic                        frameTop;
  logic                        ptrRow;
  logic                        isH1;
  logic                        isH2;
  logic                        isH3;
  logic                        isStuffSlot;
  logic [9:0]                  ptrWord;

  sts1pj_slip_buffer #(
    .WIDTH (8),
    .DEPTH (DEPTH)
  ) u_buf (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wrValid (inValid),
    .wrData  (inByte),
    .wrReady (inReady),
    .rdTake  (popReq),
    .rdValid (bufValid),
    .rdData  (bufByte),
    .fill    (fill)
  );

  // ----------------------------------------
  // slot decode
  // ----------------------------------------
  assign frameTop    = (row_r == 4'h0) && (col_r == 7'h00);
  assign ptrRow      = (row_r == `STS1PJ_PTR_ROW);
  assign isH1        = ptrRow && (col_r == `STS1PJ_H1_COL);
  assign isH2        = ptrRow && (col_r == `STS1PJ_H2_COL);
  assign isH3        = ptrRow && (col_r == `STS1PJ_H3_COL);
  assign isStuffSlot = ptrRow && (col_r == `STS1PJ_TOH_COLS) && (mode_r == sts1pj_pkg::ADJ_INC);

  always_comb begin
    unique case (mode_r)
      sts1pj_pkg::ADJ_INC: ptrWord = ptr_r ^ `STS1PJ_I_MASK;
      sts1pj_pkg::ADJ_DEC: ptrWord = ptr_r ^ `STS1PJ_D_MASK;
      sts1pj_pkg::ADJ_NONE: ptrWord = ptr_r;
      // unused enum code: send the plain word rather than latch
      default:              ptrWord = ptr_r;
    endcase
  end

  // payload moves into H3, not dropped
  always_comb begin
    popReq = 1'b0;
    if (slotTick) begin
      if (isH3) begin
        popReq = (mode_r == sts1pj_pkg::ADJ_DEC);
      end else if (col_r >= `STS1PJ_TOH_COLS) begin
        popReq = !isStuffSlot;
      end
    end
  end

  // ----------------------------------------
  // frame position, pointer and adjust decision
  // ----------------------------------------
  always_comb begin
    row_nxt   = row_r;
    col_nxt   = col_r;
    ptr_nxt   = ptr_r;
    mode_nxt  = mode_r;
    incEv_nxt = 1'b0;
    decEv_nxt = 1'b0;
    if (slotTick) begin
      if (col_r == `STS1PJ_COLS - 7'h01) begin
        col_nxt = 7'h00;
        row_nxt = (row_r == `STS1PJ_ROWS - 4'h1) ? 4'h0 : row_r + 4'h1;
      end else begin
        col_nxt = col_r + 7'h01;
      end
      if (frameTop) begin
        mode_nxt = sts1pj_pkg::ADJ_NONE;
        if (mode_r == sts1pj_pkg::ADJ_INC) begin
          ptr_nxt = (ptr_r >= `STS1PJ_PTR_MAX) ? 10'h000 : ptr_r + 10'h001;
        end else if (mode_r == sts1pj_pkg::ADJ_DEC) begin
          ptr_nxt = (ptr_r == 10'h000) ? `STS1PJ_PTR_MAX : ptr_r - 10'h001;
        // near-empty buffer asks for a stuff
        end else if (fill < (AW+1)'(LOW_MARK)) begin
          mode_nxt  = sts1pj_pkg::ADJ_INC;
          incEv_nxt = 1'b1;
        end else if (fill > (AW+1)'(HIGH_MARK)) begin
          mode_nxt  = sts1pj_pkg::ADJ_DEC;
          decEv_nxt = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // outgoing byte
  // ----------------------------------------
  always_comb begin
    out_nxt            = out_r;
    out_nxt.valid      = slotTick;
    out_nxt.frameStart = slotTick && frameTop;
    if (slotTick) begin
      if (isH1) begin
        out_nxt.data = {`STS1PJ_NDF_NORM, `STS1PJ_SS_BITS, ptrWord[9:8]};
      end else if (isH2) begin
        out_nxt.data = ptrWord[7:0];
      end else if (isStuffSlot) begin
        out_nxt.data = `STS1PJ_STUFF;
      // offset zero is the slot after H3
      end else if (popReq) begin
        out_nxt.data = bufValid ? bufByte : `STS1PJ_STUFF;
      end else begin
        out_nxt.data = `STS1PJ_IDLE_TOH;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      row_r   <= 4'h0;
      col_r   <= 7'h00;
      ptr_r   <= INIT_PTR;
      mode_r  <= sts1pj_pkg::ADJ_NONE;
      out_r   <= '0;
      incEv_r <= 1'b0;
      decEv_r <= 1'b0;
    end else begin
      row_r   <= row_nxt;
      col_r   <= col_nxt;
      ptr_r   <= ptr_nxt;
      mode_r  <= mode_nxt;
      out_r   <= out_nxt;
      incEv_r <= incEv_nxt;
      decEv_r <= decEv_nxt;
    end
  end

  assign streamOut = out_r;
  assign ptrValue  = ptr_r;
  assign ptrValid  = (ptr_r <= `STS1PJ_PTR_MAX);
  assign incEvent  = incEv_r;
  assign decEvent  = decEv_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_inc_ibits: assert property (slotTick && isH2 && mode_r == sts1pj_pkg::ADJ_INC
    |=> out_r.data == ($past(ptr_r[7:0]) ^ 8'hAA))
    else $error("increment bits not inverted");
  a_dec_dbits: assert property (slotTick && isH1 && mode_r == sts1pj_pkg::ADJ_DEC
    |=> out_r.data[1:0] == ($past(ptr_r[9:8]) ^ 2'h1))
    else $error("decrement bits not inverted");
  a_plain_word: assert property (slotTick && isH2 && mode_r == sts1pj_pkg::ADJ_NONE
    |=> out_r.data == $past(ptr_r[7:0]))
    else $error("pointer word not restored");
  a_stuff_dummy: assert property (slotTick && isStuffSlot
    |-> !popReq ##1 (out_r.valid && out_r.data == 8'h00))
    else $error("stuff slot not a dummy byte");
  a_neg_h3: assert property (slotTick && isH3 && mode_r == sts1pj_pkg::ADJ_DEC
    |-> popReq)
    else $error("H3 not filled on negative stuff");
  a_h3_idle: assert property (slotTick && isH3 && mode_r != sts1pj_pkg::ADJ_DEC
    |-> !popReq)
    else $error("H3 used without negative stuff");
  a_ptr_incr: assert property (slotTick && frameTop && mode_r == sts1pj_pkg::ADJ_INC
    |=> ptr_r == (($past(ptr_r) == 10'h30F) ? 10'h000 : $past(ptr_r) + 10'h001)
        && mode_r == sts1pj_pkg::ADJ_NONE)
    else $error("pointer not incremented");
  a_ptr_decr: assert property (slotTick && frameTop && mode_r == sts1pj_pkg::ADJ_DEC
    |=> ptr_r == (($past(ptr_r) == 10'h000) ? 10'h30F : $past(ptr_r) - 10'h001))
    else $error("pointer not decremented");
  a_stuff_start: assert property (slotTick && frameTop && mode_r == sts1pj_pkg::ADJ_NONE
    && fill < (AW+1)'(LOW_MARK) |=> mode_r == sts1pj_pkg::ADJ_INC && incEv_r)
    else $error("empty buffer not stuffed");
  a_ptr_range: assert property (ptr_r <= 10'h30F)
    else $error("pointer out of range");

  c_inc_frame: cover property (incEv_r ##[1:1000] (slotTick && isStuffSlot));
  c_dec_frame: cover property (decEv_r);
  c_buf_full:  cover property (!inReady);

endmodule

`default_nettype wire

// ---- sts1pj_term_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module sts1pj_term_model (
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  // stream from the block
  input  wire sts1pj_pkg::sts1pj_byte_t streamIn,
  // receiver view
  output logic [7:0]                    h1Seen,
  output logic [7:0]                    h2Seen,
  output logic                          ptrOk,
  output int                            payErr
);
  logic [6:0] col;
  logic [3:0] row;
  logic [9:0] word;
  logic [9:0] prevWord;
  logic [7:0] expByte;
  logic       adjInc;
  logic       adjDec;
  logic       slot;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      col = 7'h00;
      row = 4'h0;
      prevWord = 10'h000;
      expByte = 8'h01;
      adjInc = 1'b0;
      adjDec = 1'b0;
      h1Seen <= 8'h00;
      h2Seen <= 8'h00;
      ptrOk <= 1'b1;
      payErr <= 0;
    end else if (streamIn.valid) begin
      if (streamIn.frameStart) begin
        row = 4'h0;
        col = 7'h00;
        adjInc = 1'b0;
        adjDec = 1'b0;
      end else if (col == 7'h59) begin
        row = row + 4'h1;
        col = 7'h00;
      end else begin
        col = col + 7'h01;
      end
      if (row == 4'h3 && col == 7'h00) h1Seen <= streamIn.data;
      if (row == 4'h3 && col == 7'h01) begin
        h2Seen <= streamIn.data;
        word = {h1Seen[1:0], streamIn.data};
        // inverted indicator bits mark an adjusted frame
        adjInc = (word ^ prevWord) == 10'h2AA;
        adjDec = (word ^ prevWord) == 10'h155;
        // a normal word must stay in range
        if (!adjInc && !adjDec) begin
          prevWord = word;
          ptrOk <= word <= 10'h30F;
        end
      end
      slot = (col >= 7'h03) ? !(adjInc && row == 4'h3 && col == 7'h03) : (adjDec && row == 4'h3 && col == 7'h02);
      // dummy byte after H3 carries nothing
      if (adjInc && row == 4'h3 && col == 7'h03 && streamIn.data !== 8'h00) payErr <= payErr + 1;
      // payload arrives whole and in order
      if (slot) begin
        if (streamIn.data !== expByte) payErr <= payErr + 1;
        expByte = (expByte == 8'hFF) ? 8'h01 : expByte + 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

// ---- test_sts1_pointer_justification.sv ----
`timescale 1ns/1ps
`default_nettype none

module test_sts1_pointer_justification;
  logic                     sys_clk = 1'b0;
  logic                     rst_n = 1'b0;
  logic                     inValid = 1'b0;
  logic [7:0]               inByte = 8'h00;
  logic                     slotTick = 1'b0;
  logic                     inReady;
  logic                     ptrValid;
  logic                     incEvent;
  logic                     decEvent;
  logic                     ptrOk;
  logic [9:0]               ptrValue;
  logic [7:0]               h1Seen;
  logic [7:0]               h2Seen;
  logic [7:0]               nextByte = 8'h01;
  sts1pj_pkg::sts1pj_byte_t streamOut;
  int                       payErr;
  int                       errors = 0;
  int                       checks = 0;
  int                       incCnt = 0;
  int                       decCnt = 0;
  int                       cycles = 0;

  always #5 sys_clk = ~sys_clk;

  sts1pj_justifier dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .inValid(inValid), .inByte(inByte),
    .inReady(inReady), .slotTick(slotTick), .streamOut(streamOut), .ptrValue(ptrValue),
    .ptrValid(ptrValid), .incEvent(incEvent), .decEvent(decEvent));

  sts1pj_term_model term_u (.sys_clk(sys_clk), .rst_n(rst_n), .streamIn(streamOut),
    .h1Seen(h1Seen), .h2Seen(h2Seen), .ptrOk(ptrOk), .payErr(payErr));

  // ----------------------------------------
  // reporting
  // ----------------------------------------
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // 5 frames need about 4100 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (incEvent === 1'b1) incCnt++;
    if (decEvent === 1'b1) decCnt++;
    if (cycles == 10000) begin
      errors++;
      complete_run();
    end
  end

  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic push(input int n);
    for (int i = 0; i < n; i++) begin
      inValid = 1'b1;
      inByte = nextByte;
      @(posedge sys_clk);
      #1;
      nextByte = (nextByte == 8'hFF) ? 8'h01 : nextByte + 8'h01;
    end
    inValid = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask

  // one write per payload slot keeps the fill level steady unless the block adjusts
  task automatic run_frame(input logic [7:0] eH1, input logic [7:0] eH2, input logic [9:0] ePtr,
                           input int eInc, input int eDec);
    int i0;
    int d0;
    i0 = incCnt;
    d0 = decCnt;
    // whole frame, one slot per clock
    for (int s = 0; s < 810; s++) begin
      slotTick = 1'b1;
      inValid = (s % 90) >= 3;
      inByte = nextByte;
      @(posedge sys_clk);
      #1;
      if (inValid) nextByte = (nextByte == 8'hFF) ? 8'h01 : nextByte + 8'h01;
    end
    slotTick = 1'b0;
    inValid = 1'b0;
    @(posedge sys_clk);
    #1;
    check("h1", 16'(h1Seen), 16'(eH1));
    check("h2", 16'(h2Seen), 16'(eH2));
    check("ptrValue", 16'(ptrValue), 16'(ePtr));
    check("incEvents", 16'(incCnt - i0), 16'(eInc));
    check("decEvents", 16'(decCnt - d0), 16'(eDec));
    check("ptrValid", 16'(ptrValid), 16'h0001);
    check("ptrOk", 16'(ptrOk), 16'h0001);
    check("payErr", 16'(payErr), 16'h0000);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic scenario_reset();
    check("ptrValue", 16'(ptrValue), 16'h0000);
    check("inReady", 16'(inReady), 16'h0001);
  endtask

  task automatic scenario_increment();
    push(1);
    run_frame(8'h62, 8'hAA, 10'h000, 1, 0);
    run_frame(8'h60, 8'h01, 10'h001, 0, 0);
    run_frame(8'h60, 8'h01, 10'h001, 0, 0);
  endtask

  task automatic scenario_decrement();
    push(13);
    run_frame(8'h61, 8'h54, 10'h001, 0, 1);
    run_frame(8'h60, 8'h00, 10'h000, 0, 0);
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    scenario_reset();
    scenario_increment();
    scenario_decrement();
    complete_run();
  end
endmodule

`default_nettype wire
